// ==== rtl/fap_pkg.sv ====
// shared constants for the buffer access port and disk interrupt bank
package fap_pkg;

  // ---------------------------------------------------------------
  // register addresses on the microcontroller data space
  // ---------------------------------------------------------------
  localparam logic [15:0] FAP_ADDR_BYTE0 = 16'hf0e0;
  localparam logic [15:0] FAP_ADDR_BYTE1 = 16'hf0e1;
  localparam logic [15:0] FAP_ADDR_BYTE2 = 16'hf0e2;
  localparam logic [15:0] FAP_ADDR_BYTE3 = 16'hf0e3;
  localparam logic [15:0] FAP_ADDR_LOW = 16'hf0e4;
  localparam logic [15:0] FAP_ADDR_HIGH = 16'hf0e5;
  localparam logic [15:0] FAP_ADDR_SRC0 = 16'hf0e6;
  localparam logic [15:0] FAP_ADDR_MASK0 = 16'hf0e7;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int FAP_BUF_AW = 13;
  localparam int FAP_WORD_W = 32;
  localparam int FAP_HI_ADDR_W = 5;

  // ---------------------------------------------------------------
  // buffer_addr_high_ctrl fields
  // ---------------------------------------------------------------
  localparam int FAP_DIR_BIT = 7;
  localparam int FAP_BUSY_BIT = 6;
  localparam int FAP_RSV_BIT = 5;
  localparam logic FAP_DIR_WRITE = 1'b0;
  localparam logic FAP_DIR_READ = 1'b1;

  // ---------------------------------------------------------------
  // disk_irq_source0 fields
  // ---------------------------------------------------------------
  localparam int FAP_SRC_MANUAL = 0;
  localparam int FAP_SRC_PEND1 = 1;
  localparam int FAP_SRC_MISMATCH = 2;
  localparam int FAP_SRC_HOSTDONE = 3;
  localparam int FAP_SRC_HOSTPEND = 4;
  localparam int FAP_SRC_DISKDONE = 5;
  localparam int FAP_SRC_AUTOERR = 6;
  localparam int FAP_SRC_COMPLETE = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FAP_RST_BYTE = 8'h00;
  localparam logic [12:0] FAP_RST_ADDR = 13'h0000;
  localparam logic [31:0] FAP_RST_WORD = 32'h0000_0000;

endpackage

// ==== rtl/fap_access_engine.sv ====
// buffer access engine: one 32-bit commit or fetch per request
`timescale 1ns/1ps
module fap_access_engine (
  input wire logic clk,
  input wire logic rst,
  input wire logic startCommit,
  input wire logic startFetch,
  input wire logic bufAck,
  output logic bufReq,
  output logic bufWe,
  output logic accessDone
);
  import fap_pkg::*;

  typedef enum logic [1:0] {ENG_IDLE, ENG_COMMIT, ENG_FETCH} fap_eng_t;

  fap_eng_t state_reg;
  fap_eng_t state_next;
  logic req_next;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // starts are only honoured when idle; caller gates on busy too
  assign accessDone = bufReq & bufAck;
  assign req_next = (state_next != ENG_IDLE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ENG_IDLE: begin
        if (startFetch) begin
          state_next = ENG_FETCH;
        end else if (startCommit) begin
          state_next = ENG_COMMIT;
        end
      end
      ENG_COMMIT, ENG_FETCH: begin
        if (bufAck) begin
          state_next = ENG_IDLE;
        end
      end
    endcase
  end

  // request stays up until the buffer acknowledges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ENG_IDLE;
      bufReq <= 1'b0;
      bufWe <= 1'b0;
    end else begin
      state_reg <= state_next;
      bufReq <= req_next;
      bufWe <= (state_next == ENG_COMMIT);
    end
  end

endmodule

// ==== rtl/fap_irq_bank.sv ====
// disk interrupt source register 0 with its enable mask
`timescale 1ns/1ps
module fap_irq_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrSource,
  input wire logic wrEnable,
  input wire logic [7:0] wrData,
  input wire logic transferStart,
  input wire logic autoPhase,
  input wire logic evtManualIrq,
  input wire logic secondRegPending,
  input wire logic evtByteMismatch,
  input wire logic evtHostDone,
  input wire logic evtHostPending,
  input wire logic evtDiskDone,
  input wire logic evtAutoSeqError,
  input wire logic evtCompletion,
  output logic [7:0] sourceValue,
  output logic [7:0] enableValue,
  output logic diskIrq
);
  import fap_pkg::*;

  logic [7:0] source_reg;
  logic [7:0] source_next;
  logic [7:0] setBits;
  logic [7:0] clrBits;

  // ---------------------------------------------------------------
  // set and clear terms
  // ---------------------------------------------------------------
  // manual flag only outside the automatic phase
  assign setBits[FAP_SRC_MANUAL] = evtManualIrq & ~autoPhase;
  assign setBits[FAP_SRC_PEND1] = 1'b0;
  assign setBits[FAP_SRC_MISMATCH] = evtByteMismatch;
  assign setBits[FAP_SRC_HOSTDONE] = evtHostDone;
  assign setBits[FAP_SRC_HOSTPEND] = evtHostPending;
  assign setBits[FAP_SRC_DISKDONE] = evtDiskDone;
  assign setBits[FAP_SRC_AUTOERR] = evtAutoSeqError;
  assign setBits[FAP_SRC_COMPLETE] = evtCompletion;

  // write-one-to-clear plus auto clear of both done flags
  assign clrBits = (wrSource ? wrData : 8'h00) |
    (transferStart ? ((8'h01 << FAP_SRC_HOSTDONE) |
    (8'h01 << FAP_SRC_DISKDONE)) : 8'h00);

  // a set in the clearing cycle wins so no event is lost
  assign source_next = (source_reg & ~clrBits) | setBits;

  // bit 1 is a live view of the second register
  assign sourceValue = {source_reg[7:2], secondRegPending, source_reg[0]};

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      source_reg <= FAP_RST_BYTE;
      enableValue <= FAP_RST_BYTE;
      diskIrq <= 1'b0;
    end else begin
      source_reg <= source_next;
      if (wrEnable) begin
        enableValue <= wrData;
      end
      diskIrq <= |(sourceValue & enableValue);
    end
  end

endmodule

// ==== rtl/fap_regs.sv ====
// buffer access port and disk interrupt registers, top level
`timescale 1ns/1ps
module fap_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] mcuAddr,
  input wire logic mcuWrEn,
  input wire logic mcuRdEn,
  input wire logic [7:0] mcuWrData,
  output logic [7:0] mcuRdData,
  output logic bufReq,
  output logic bufWe,
  output logic [fap_pkg::FAP_BUF_AW-1:0] bufAddr,
  output logic [fap_pkg::FAP_WORD_W-1:0] bufWrData,
  input wire logic bufAck,
  input wire logic [fap_pkg::FAP_WORD_W-1:0] bufRdData,
  input wire logic transferStart,
  input wire logic autoPhase,
  input wire logic evtManualIrq,
  input wire logic secondRegPending,
  input wire logic evtByteMismatch,
  input wire logic evtHostDone,
  input wire logic evtHostPending,
  input wire logic evtDiskDone,
  input wire logic evtAutoSeqError,
  input wire logic evtCompletion,
  output logic diskIrq
);
  import fap_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // merge a byte write into the high part of the access address
  function automatic logic [FAP_BUF_AW-1:0] fap_merge_high(
    input logic [FAP_BUF_AW-1:0] addr,
    input logic [7:0] data
  );
    fap_merge_high = {data[FAP_HI_ADDR_W-1:0], addr[7:0]};
  endfunction

  // merge a byte write into the low part of the access address
  function automatic logic [FAP_BUF_AW-1:0] fap_merge_low(
    input logic [FAP_BUF_AW-1:0] addr,
    input logic [7:0] data
  );
    fap_merge_low = {addr[FAP_BUF_AW-1:8], data};
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [FAP_BUF_AW-1:0] addr_reg;
  logic [FAP_BUF_AW-1:0] addr_next;
  logic dir_reg;
  logic [7:0] dataByte_reg [4];
  logic [7:0] rdData_next;
  logic accessBusy;
  logic accessDone;
  logic isFetch;
  logic startCommit;
  logic startFetch;
  logic [FAP_BUF_AW-1:0] addrIssue;
  logic [FAP_WORD_W-1:0] wordAssembled;
  logic [7:0] sourceValue;
  logic [7:0] enableValue;
  logic [7:0] highRead;
  logic selByte0;
  logic selByte1;
  logic selByte2;
  logic selByte3;
  logic selLow;
  logic selHigh;
  logic selSource;
  logic selEnable;
  logic wrLow;
  logic wrHigh;
  logic rdByte3;
  logic wrByte3;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign selByte0 = (mcuAddr == FAP_ADDR_BYTE0);
  assign selByte1 = (mcuAddr == FAP_ADDR_BYTE1);
  assign selByte2 = (mcuAddr == FAP_ADDR_BYTE2);
  assign selByte3 = (mcuAddr == FAP_ADDR_BYTE3);
  assign selLow = (mcuAddr == FAP_ADDR_LOW);
  assign selHigh = (mcuAddr == FAP_ADDR_HIGH);
  assign selSource = (mcuAddr == FAP_ADDR_SRC0);
  assign selEnable = (mcuAddr == FAP_ADDR_MASK0);
  assign wrLow = mcuWrEn & selLow;
  assign wrHigh = mcuWrEn & selHigh;
  assign wrByte3 = mcuWrEn & selByte3;
  assign rdByte3 = mcuRdEn & selByte3;

  // ---------------------------------------------------------------
  // access triggers
  // ---------------------------------------------------------------
  // the engine owns the buffer; a trigger seen while busy is dropped
  assign startFetch = ~accessBusy &
    ((wrHigh & (mcuWrData[FAP_DIR_BIT] == FAP_DIR_READ)) |
     (rdByte3 & (dir_reg == FAP_DIR_READ)));
  assign startCommit = ~accessBusy & wrByte3 &
    (dir_reg == FAP_DIR_WRITE);

  // a high-byte write must use its own new address bits
  assign addrIssue = wrHigh ? fap_merge_high(addr_reg, mcuWrData) : addr_reg;

  // the fourth byte arrives in the same cycle as the commit trigger
  assign wordAssembled = {mcuWrData, dataByte_reg[2], dataByte_reg[1],
    dataByte_reg[0]};

  // ---------------------------------------------------------------
  // access address next value
  // ---------------------------------------------------------------
  // firmware writes win over the post-access increment
  assign addr_next = wrLow ? fap_merge_low(addr_reg, mcuWrData) :
    wrHigh ? fap_merge_high(addr_reg, mcuWrData) :
    accessDone ? addr_reg + 13'h0001 : addr_reg;

  // address and direction registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= FAP_RST_ADDR;
      dir_reg <= FAP_DIR_WRITE;
    end else begin
      addr_reg <= addr_next;
      if (wrHigh) begin
        dir_reg <= mcuWrData[FAP_DIR_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // data byte registers
  // ---------------------------------------------------------------
  // a finished fetch overwrites all four bytes at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        dataByte_reg[i] <= FAP_RST_BYTE;
      end
    end else if (accessDone && isFetch) begin
      for (int i = 0; i < 4; i++) begin
        dataByte_reg[i] <= bufRdData[8*i +: 8];
      end
    end else if (mcuWrEn) begin
      if (selByte0) begin
        dataByte_reg[0] <= mcuWrData;
      end
      if (selByte1) begin
        dataByte_reg[1] <= mcuWrData;
      end
      if (selByte2) begin
        dataByte_reg[2] <= mcuWrData;
      end
      if (selByte3) begin
        dataByte_reg[3] <= mcuWrData;
      end
    end
  end

  // buffer address and write word are held for the whole request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bufAddr <= FAP_RST_ADDR;
      bufWrData <= FAP_RST_WORD;
    end else if (startFetch) begin
      bufAddr <= addrIssue;
    end else if (startCommit) begin
      bufAddr <= addr_reg;
      bufWrData <= wordAssembled;
    end
  end

  // ---------------------------------------------------------------
  // engine and interrupt bank
  // ---------------------------------------------------------------
  fap_access_engine u_engine (
    .clk(clk),
    .rst(rst),
    .startCommit(startCommit),
    .startFetch(startFetch),
    .bufAck(bufAck),
    .bufReq(bufReq),
    .bufWe(bufWe),
    .accessDone(accessDone)
  );

  // busy is the pending request itself
  assign accessBusy = bufReq;
  assign isFetch = ~bufWe;

  fap_irq_bank u_irq (
    .clk(clk),
    .rst(rst),
    .wrSource(mcuWrEn & selSource),
    .wrEnable(mcuWrEn & selEnable),
    .wrData(mcuWrData),
    .transferStart(transferStart),
    .autoPhase(autoPhase),
    .evtManualIrq(evtManualIrq),
    .secondRegPending(secondRegPending),
    .evtByteMismatch(evtByteMismatch),
    .evtHostDone(evtHostDone),
    .evtHostPending(evtHostPending),
    .evtDiskDone(evtDiskDone),
    .evtAutoSeqError(evtAutoSeqError),
    .evtCompletion(evtCompletion),
    .sourceValue(sourceValue),
    .enableValue(enableValue),
    .diskIrq(diskIrq)
  );

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // reserved bit 5 always reads zero
  assign highRead = {dir_reg, accessBusy, 1'b0,
    addr_reg[FAP_BUF_AW-1:8]};
  assign rdData_next = selByte0 ? dataByte_reg[0] :
    selByte1 ? dataByte_reg[1] :
    selByte2 ? dataByte_reg[2] :
    selByte3 ? dataByte_reg[3] :
    selLow ? addr_reg[7:0] :
    selHigh ? highRead :
    selSource ? sourceValue :
    selEnable ? enableValue : 8'h00;

  // read data lands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mcuRdData <= FAP_RST_BYTE;
    end else begin
      mcuRdData <= mcuRdEn ? rdData_next : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_fetch_sets_busy: assert property (
    startFetch |=> accessBusy && !bufWe && bufAddr == $past(addrIssue))
    else $error("fetch did not raise busy at the issued address");

  a_commit_word_out: assert property (
    startCommit |=> accessBusy && bufWe &&
      bufWrData == $past(wordAssembled) && bufAddr == $past(addr_reg))
    else $error("commit did not present the assembled word");

  // sized add so the top address wraps to zero as the register does
  a_addr_increments: assert property (
    accessDone && !wrLow && !wrHigh |=>
      addr_reg == $past(addr_reg) + 13'h0001)
    else $error("address did not advance after access");

  // a trigger while busy must not disturb the request in flight
  a_busy_holds_req: assert property (
    accessBusy && !bufAck |=> accessBusy && $stable(bufAddr) &&
      $stable(bufWe))
    else $error("request changed before the buffer acknowledged");

  // firmware address writes land even while an access runs
  a_low_write_lands: assert property (
    wrLow |=> addr_reg[7:0] == $past(mcuWrData))
    else $error("low byte write did not load the address");

  a_dir_write_lands: assert property (
    wrHigh |=> dir_reg == $past(mcuWrData[FAP_DIR_BIT]) &&
      addr_reg[FAP_BUF_AW-1:8] == $past(mcuWrData[FAP_HI_ADDR_W-1:0]))
    else $error("high byte write did not load direction and address");

  a_fetch_loads_bytes: assert property (
    accessDone && isFetch |=> dataByte_reg[3] == $past(bufRdData[31:24])
      && dataByte_reg[0] == $past(bufRdData[7:0]))
    else $error("fetched word not loaded into data bytes");

  a_high_readback: assert property (
    mcuRdEn && selHigh |=> mcuRdData[FAP_RSV_BIT] == 1'b0 &&
      mcuRdData[FAP_BUSY_BIT] == $past(accessBusy))
    else $error("high byte read shows wrong busy or reserved bit");

  a_no_early_fetch: assert property (
    !accessBusy && !rdByte3 && !wrHigh |=> !accessBusy || bufWe)
    else $error("prefetch started without a byte three read");

  a_w1c_completion: assert property (
    mcuWrEn && selSource && mcuWrData[FAP_SRC_COMPLETE] && !evtCompletion
      |=> !sourceValue[FAP_SRC_COMPLETE])
    else $error("write one did not clear completion flag");

  a_start_clears_done: assert property (
    transferStart && !evtHostDone && !evtDiskDone |=>
      !sourceValue[FAP_SRC_HOSTDONE] && !sourceValue[FAP_SRC_DISKDONE])
    else $error("transfer start left a done flag set");

  a_auto_phase_quiet: assert property (
    evtManualIrq && autoPhase && !sourceValue[FAP_SRC_MANUAL] |=>
      !sourceValue[FAP_SRC_MANUAL])
    else $error("manual flag set during automatic phase");

  a_pend_is_live: assert property (
    sourceValue[FAP_SRC_PEND1] == secondRegPending)
    else $error("pending bit does not follow second register");

  a_event_sticks: assert property (
    evtCompletion ##1 !(mcuWrEn && selSource) |->
      sourceValue[FAP_SRC_COMPLETE])
    else $error("completion flag not held");

  a_irq_enabled: assert property (
    (|(sourceValue & enableValue)) [*2] |-> diskIrq)
    else $error("enabled source did not raise interrupt");

  // main scenarios: fetch, commit, interrupt raise and address wrap
  c_fetch_done: cover property (startFetch ##[1:20] accessDone);
  c_addr_wrap: cover property (accessDone && addr_reg == 13'h1fff);
  c_commit_done: cover property (startCommit ##[1:20] accessDone);
  c_irq_raised: cover property (!diskIrq ##1 diskIrq);

endmodule

// ==== verif/test_fap_regs.sv ====
// self-checking bench for the buffer access port and interrupt bank
`timescale 1ns/1ps
module test_fap_regs;
  import fap_pkg::*;

  // ---------------------------------------------------------------
  // signals and design instance
  // ---------------------------------------------------------------
  logic clk, rst, mcuWrEn, mcuRdEn, bufAck, transferStart, autoPhase;
  logic secondRegPending, bufReq, bufWe, diskIrq;
  logic [15:0] mcuAddr;
  logic [7:0] mcuWrData, mcuRdData, evt, rdVal;
  logic [12:0] bufAddr;
  logic [31:0] bufWrData, bufRdData;
  int mismatches, checks, cycles;

  fap_regs fap_regs_i (
    .clk(clk), .rst(rst), .mcuAddr(mcuAddr), .mcuWrEn(mcuWrEn),
    .mcuRdEn(mcuRdEn), .mcuWrData(mcuWrData), .mcuRdData(mcuRdData),
    .bufReq(bufReq), .bufWe(bufWe), .bufAddr(bufAddr),
    .bufWrData(bufWrData), .bufAck(bufAck), .bufRdData(bufRdData),
    .transferStart(transferStart), .autoPhase(autoPhase),
    .evtManualIrq(evt[0]), .secondRegPending(secondRegPending),
    .evtByteMismatch(evt[2]), .evtHostDone(evt[3]),
    .evtHostPending(evt[4]), .evtDiskDone(evt[5]),
    .evtAutoSeqError(evt[6]), .evtCompletion(evt[7]),
    .diskIrq(diskIrq)
  );

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // whole run needs well under 1000 cycles; ceiling leaves slack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // helper tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // strobes rise and fall on falling edges; one idle cycle between
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    mcuAddr = a;
    mcuWrData = d;
    mcuWrEn = 1'b1;
    @(negedge clk);
    mcuWrEn = 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdchk(input string name, input logic [15:0] a,
                       input logic [7:0] exp);
    @(negedge clk);
    mcuAddr = a;
    mcuRdEn = 1'b1;
    @(negedge clk);
    mcuRdEn = 1'b0;
    chk(name, 32'(mcuRdData), 32'(exp));
  endtask

  task automatic pulse(input logic [7:0] m);
    @(negedge clk);
    evt = m;
    @(negedge clk);
    evt = 8'h00;
  endtask

  // plays the buffer memory: checks the request, holds it, then acks
  task automatic serve(input logic we, input logic [12:0] a,
                       input logic [31:0] word, input logic dir);
    int n;
    n = 0;
    while (bufReq !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("bufReq", 32'(bufReq), 32'h1);
    chk("bufWe", 32'(bufWe), 32'(we));
    chk("bufAddr", 32'(bufAddr), 32'(a));
    if (we) chk("bufWrData", bufWrData, word);
    rdchk("busy", FAP_ADDR_HIGH, {dir, 2'b10, a[12:8]});
    bufRdData = word;
    bufAck = 1'b1;
    @(negedge clk);
    bufAck = 1'b0;
    bufRdData = ~word; // released bus shows junk, not the last word
    @(negedge clk);
    chk("bufReq low", 32'(bufReq), 32'h0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    mcuAddr = 16'h0000;
    mcuWrData = 8'h00;
    mcuWrEn = 1'b0;
    mcuRdEn = 1'b0;
    bufAck = 1'b0;
    bufRdData = 32'h0000_0000;
    transferStart = 1'b0;
    autoPhase = 1'b0;
    secondRegPending = 1'b0;
    evt = 8'h00;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;

    // reset values, then an unmapped write and read
    for (int i = 0; i < 8; i++) begin
      rdchk("reset", FAP_ADDR_BYTE0 + 16'(i), 8'h00);
    end
    wr(16'hf0e8, 8'hff);
    rdchk("unmapped", 16'hf0e8, 8'h00);
    rdchk("low", FAP_ADDR_LOW, 8'h00);
    $display("test reset done");

    // read setup one below the top address, then wrap on the second fetch
    wr(FAP_ADDR_LOW, 8'hfe);
    wr(FAP_ADDR_HIGH, 8'h9f);
    serve(1'b0, 13'h1ffe, 32'ha1b2_c3d4, 1'b1);
    rdchk("high", FAP_ADDR_HIGH, 8'h9f);
    rdchk("low", FAP_ADDR_LOW, 8'hff);
    rdchk("byte0", FAP_ADDR_BYTE0, 8'hd4);
    rdchk("byte1", FAP_ADDR_BYTE1, 8'hc3);
    rdchk("byte2", FAP_ADDR_BYTE2, 8'hb2);
    chk("no prefetch", 32'(bufReq), 32'h0);
    rdchk("byte3", FAP_ADDR_BYTE3, 8'ha1);
    serve(1'b0, 13'h1fff, 32'h5566_7788, 1'b1);
    rdchk("wrap low", FAP_ADDR_LOW, 8'h00);
    rdchk("wrap high", FAP_ADDR_HIGH, 8'h80);
    rdchk("byte0 next", FAP_ADDR_BYTE0, 8'h88);
    $display("test read done");

    // write direction: reserved bit ignored, no fetch on setup
    wr(FAP_ADDR_HIGH, 8'h20);
    wr(FAP_ADDR_LOW, 8'h10);
    rdchk("high rsv", FAP_ADDR_HIGH, 8'h00);
    chk("no fetch", 32'(bufReq), 32'h0);
    wr(FAP_ADDR_BYTE0, 8'h11);
    wr(FAP_ADDR_BYTE1, 8'h22);
    wr(FAP_ADDR_BYTE2, 8'h33);
    wr(FAP_ADDR_BYTE3, 8'h44);
    serve(1'b1, 13'h0010, 32'h4433_2211, 1'b0);
    rdchk("low inc", FAP_ADDR_LOW, 8'h11);
    rdchk("byte2", FAP_ADDR_BYTE2, 8'h33);
    // only byte three rewritten: older bytes stay in the word
    wr(FAP_ADDR_BYTE3, 8'h99);
    serve(1'b1, 13'h0011, 32'h9933_2211, 1'b0);
    rdchk("low inc2", FAP_ADDR_LOW, 8'h12);
    $display("test write done");

    // each event bit: set, survives a zero write, clears on one
    wr(FAP_ADDR_MASK0, 8'hfd);
    rdchk("mask", FAP_ADDR_MASK0, 8'hfd);
    for (int b = 0; b < 8; b++) begin
      if (b != 1) begin
        pulse(8'h01 << b);
        rdchk("src set", FAP_ADDR_SRC0, 8'h01 << b);
        chk("irq on", 32'(diskIrq), 32'h1);
        wr(FAP_ADDR_SRC0, 8'h00);
        rdchk("src hold", FAP_ADDR_SRC0, 8'h01 << b);
        wr(FAP_ADDR_SRC0, 8'h01 << b);
        rdchk("src clr", FAP_ADDR_SRC0, 8'h00);
        chk("irq off", 32'(diskIrq), 32'h0);
      end
    end
    autoPhase = 1'b1;
    pulse(8'h01);
    rdchk("auto phase", FAP_ADDR_SRC0, 8'h00);
    autoPhase = 1'b0;
    secondRegPending = 1'b1;
    rdchk("pend1", FAP_ADDR_SRC0, 8'h02);
    wr(FAP_ADDR_SRC0, 8'h02);
    rdchk("pend1 ro", FAP_ADDR_SRC0, 8'h02);
    chk("pend1 masked", 32'(diskIrq), 32'h0);
    secondRegPending = 1'b0;
    $display("test events done");

    // masking and the transfer start clear
    wr(FAP_ADDR_MASK0, 8'h00);
    pulse(8'hfd);
    rdchk("all set", FAP_ADDR_SRC0, 8'hfd);
    chk("all masked", 32'(diskIrq), 32'h0);
    @(negedge clk);
    transferStart = 1'b1;
    @(negedge clk);
    transferStart = 1'b0;
    rdchk("start clr", FAP_ADDR_SRC0, 8'hd5);
    wr(FAP_ADDR_MASK0, 8'h80);
    @(negedge clk);
    chk("mask on", 32'(diskIrq), 32'h1);
    wr(FAP_ADDR_SRC0, 8'hff);
    rdchk("clr all", FAP_ADDR_SRC0, 8'h00);
    chk("irq idle", 32'(diskIrq), 32'h0);
    $display("test mask done");
    stop_test();
  end
endmodule
